// ---- inc/quad_timer_consts.svh ----
// Register map, field positions and codes for the quad timer
`ifndef QUAD_TIMER_CONSTS_SVH
`define QUAD_TIMER_CONSTS_SVH
// Register kinds; timer i occupies byte offsets 16*i .. 16*i+12
`define QT_K_CTRL     3'h0
`define QT_K_COUNT    3'h1
`define QT_K_DATA     3'h2
`define QT_K_STAT     3'h3
`define QT_K_IRQ      3'h4
`define QT_K_NONE     3'h7
`define QT_OFF_CTRL   8'h00
`define QT_OFF_COUNT  8'h04
`define QT_OFF_DATA   8'h08
`define QT_OFF_STAT   8'h0C
`define QT_OFF_IRQ    8'h40
// Control word fields
`define QT_B_RUN      0
`define QT_B_ECAP     1
`define QT_B_FMEAS    2
`define QT_B_CSEL     4
// Status word fields
`define QT_B_OVF      0
`define QT_B_CAP      1
// Interrupt control word: enables in [3:0]
`define QT_B_MIE      4
// Clock select codes
`define QT_CSEL_SLOW  2'h0
`define QT_CSEL_FAST  2'h1
`define QT_CSEL_EXT   2'h2
`define QT_CSEL_PAIR  2'h3
`define QT_CNT_MAX    8'hFF
`define QT_CNT_ZERO   8'h00
`define QT_VEC_BASE   16'h0020
`define QT_VEC_STEP   16'h0002
`define QT_RESP_OK    2'h0
`define QT_RESP_ERR   2'h2
`endif

// ---- inc/quad_timer_pkg.sv ----
// Types for the quad timer
`default_nettype none
package quad_timer_pkg;
  typedef enum logic [2:0] {
    PH_IDLE  = 3'h1,
    PH_ARMED = 3'h2,
    PH_COUNT = 3'h4
  } phase_e;

  typedef struct packed {
    logic [3:0][7:0] cnt;
    logic [3:0][7:0] dat;
    logic [3:0][1:0] csel;
    phase_e [3:0]    ph;
    logic [3:0]      run;
    logic [3:0]      ovf;
    logic [3:0]      irq;
    logic [3:0]      ien;
    logic            master_irq_enable;
    logic [1:0]      ecap;
    logic [1:0]      fmeas;
    logic [1:0]      capf;
    logic [1:0]      fm_go;
    logic [3:0]      clk_prev;
    logic [1:0]      cap_prev;
    logic            tb_prev;
    logic            aw_have;
    logic            w_have;
    logic [7:0]      aw_addr;
    logic [31:0]     w_data;
    logic [3:0]      w_strb;
    logic            bvalid;
    logic [1:0]      bresp;
    logic            rvalid;
    logic [1:0]      rresp;
    logic [31:0]     rdata;
  } state_s;
endpackage : quad_timer_pkg
`default_nettype wire

// ---- rtl/quad_timer.sv ----
// Four 8-bit reload/capture timers behind an AXI4-Lite slave
// Behaviour
// - Each timer is an 8-bit up-counter stepping on falling edges of its clock.
// - Writing a counter also writes the same value into its data register.
// - Counter reads and writes are always accepted; internal-clock accuracy not guaranteed.
// - Every overflow, except that of the lower timer of a 16-bit pair, pulses the timer interrupt and inverts its overflow flag.
// - Overflow flags of timers 0 and 1 drive two output pins.
// - Processor interrupt needs master and own enable; vectors 0020H to 0026H.
// - Auto-reload: overflow loads the data register into the counter, counting continues.
// - Run bit 1 starts counting, 0 halts it.
// - In a 16-bit pair the lower run bit controls both; upper ignored.
// - A 16-bit overflow pulses the upper interrupt and toggles the upper flag.
// - Counting starts on second clock fall after run set, stops on first after clear.
// - Capture mode: capture input level change copies counter into data register.
// - Capture mode never reloads; overflow wraps FFH to 00H.
// - Capture sets a flag blocking further captures; status read clears it.
// - Timer 1 clocked by timer 0 overflow forms a 16-bit capture pair.
// - Capture completes within one timer clock period of the input change.
// - With frequency bit set, counting starts at the next 64 Hz falling edge.
// - Gate pulse clears the frequency bit; count halts at next clock fall.
// - Timers 0 and 2 overflows can clock timers 1 and 3.
// - External clocks are sampled by the system clock; levels exceed one cycle.
// - Writing the data register leaves the counter unchanged.
`timescale 1ns/100ps
`default_nettype none
`include "quad_timer_consts.svh"

module quad_timer (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Timer clock sources
  input  wire logic        slow_timebase_clock,
  input  wire logic        fast_osc_clock,
  input  wire logic        ext_clk_even_timers,
  input  wire logic        ext_clk_odd_timers,
  // Frequency measurement timing
  input  wire logic        timebase_64hz,
  input  wire logic        measure_gate_pulse,
  // Capture inputs
  input  wire logic        capture_pin0,
  input  wire logic        capture_pin1,
  // Overflow flag pins
  output logic             t0_overflow_toggle,
  output logic             t1_overflow_toggle,
  // Interrupts
  output logic             t0_irq,
  output logic             t1_irq,
  output logic             t2_irq,
  output logic             t3_irq,
  output logic             cpu_irq_req,
  output logic [15:0]      cpu_irq_vector
);

  quad_timer_pkg::state_s st_q;
  quad_timer_pkg::state_s st_d;
  logic [3:0] src_now;
  logic [3:0] src_fall;
  logic [3:0] tfall;
  logic [3:0] run_req;
  logic [3:0] cnting;
  logic [3:0] inc;
  logic [3:0] ovf_ev;
  logic [3:0] irq_ev;
  logic [3:0] wrap_zero;
  logic [1:0] pair;
  logic [1:0] capmode;
  logic [1:0] cap_edge;
  logic [1:0] cap_ev;
  logic       tb_fall;
  logic       wr_go;
  logic       rd_go;
  logic [2:0] wkind;
  logic [2:0] rkind;
  logic [1:0] wt;
  logic [1:0] rt;
  logic [7:0] wd;
  logic [31:0] rword;
  function automatic logic [2:0] reg_kind(input logic [7:0] a);
    reg_kind = (a[7:6] == 2'h0) ? {1'b0, a[3:2]} :
               (a == `QT_OFF_IRQ) ? `QT_K_IRQ : `QT_K_NONE;
  endfunction : reg_kind
  // Pins are synchronous; one stored sample gives the falling edge
  assign src_now  = {ext_clk_odd_timers, ext_clk_even_timers, fast_osc_clock,
                     slow_timebase_clock};
  assign src_fall = st_q.clk_prev & ~src_now;
  assign tb_fall  = st_q.tb_prev & ~timebase_64hz;
  assign pair[0]  = st_q.csel[1] == `QT_CSEL_PAIR;
  assign pair[1]  = st_q.csel[3] == `QT_CSEL_PAIR;
  assign run_req  = {st_q.run[3], st_q.run[2] | st_q.fm_go[1],
                     st_q.run[1], st_q.run[0] | st_q.fm_go[0]};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_tmr
      localparam int EXT = 2 + (gi % 2);
      assign tfall[gi] = (st_q.csel[gi] == `QT_CSEL_FAST) ? src_fall[1] :
                         (st_q.csel[gi] == `QT_CSEL_EXT)  ? src_fall[EXT] :
                         src_fall[0];
      assign cnting[gi] = tfall[gi] & (st_q.ph[gi] != quad_timer_pkg::PH_IDLE)
                          & run_req[gi];
      assign ovf_ev[gi] = inc[gi] & (st_q.cnt[gi] == `QT_CNT_MAX);
      if (gi % 2 == 0)
      begin : g_low
        assign inc[gi] = cnting[gi];
        // Lower half reloads only with the whole pair
        assign wrap_zero[gi] = ((gi == 0) & capmode[0]) |
                               (pair[gi/2] & (st_q.cnt[gi+1] != `QT_CNT_MAX));
        assign irq_ev[gi] = ovf_ev[gi] & ~pair[gi/2];
      end
      else
      begin : g_up
        // Upper timer ignores its run bit when paired
        assign inc[gi] = pair[gi/2] ? ovf_ev[gi-1] : cnting[gi];
        assign wrap_zero[gi] = (gi == 1) & capmode[1];
        assign irq_ev[gi] = ovf_ev[gi];
      end
    end
  endgenerate
  // Capture detect; any level change counts
  assign capmode[0]  = st_q.ecap[0] & ~st_q.fmeas[0];
  assign capmode[1]  = st_q.ecap[1] | (pair[0] & capmode[0]);
  assign cap_edge[0] = st_q.cap_prev[0] ^ capture_pin0;
  assign cap_edge[1] = st_q.cap_prev[1] ^ capture_pin1;
  assign cap_ev[0]   = cap_edge[0] & capmode[0] & ~st_q.capf[0] & run_req[0]
                       & (st_q.ph[0] == quad_timer_pkg::PH_COUNT);
  assign cap_ev[1]   = pair[0] ? cap_ev[0] :
                       (cap_edge[1] & st_q.ecap[1] & ~st_q.capf[1] & st_q.run[1]
                       & (st_q.ph[1] == quad_timer_pkg::PH_COUNT));
  // Bus decode
  assign wr_go = st_q.aw_have & st_q.w_have & ~st_q.bvalid;
  assign wkind = reg_kind(st_q.aw_addr);
  assign wt    = st_q.aw_addr[5:4];
  assign wd    = st_q.w_data[7:0];
  assign rd_go = arvalid & ~st_q.rvalid;
  assign rkind = reg_kind(araddr);
  assign rt    = araddr[5:4];
  always_comb
  begin
    rword = 32'h0000_0000;
    case (rkind)
      `QT_K_CTRL:
      begin
        rword[`QT_B_RUN] = st_q.run[rt];
        rword[`QT_B_ECAP] = (rt < 2'h2) & st_q.ecap[rt[0]];
        rword[`QT_B_FMEAS] = (rt == 2'h0) ? st_q.fmeas[0] :
                             (rt == 2'h2) ? st_q.fmeas[1] : 1'b0;
        rword[`QT_B_CSEL+1:`QT_B_CSEL] = st_q.csel[rt];
      end
      `QT_K_COUNT: rword[7:0] = st_q.cnt[rt];
      `QT_K_DATA:  rword[7:0] = st_q.dat[rt];
      `QT_K_STAT:
      begin
        rword[`QT_B_OVF] = st_q.ovf[rt];
        rword[`QT_B_CAP] = (rt < 2'h2) & st_q.capf[rt[0]];
      end
      `QT_K_IRQ:
      begin
        rword[3:0] = st_q.ien;
        rword[`QT_B_MIE] = st_q.master_irq_enable;
      end
      default: rword = 32'h0000_0000;
    endcase
  end
  always_comb
  begin
    st_d = st_q;
    st_d.irq = 4'h0;
    st_d.clk_prev = src_now;
    st_d.cap_prev = {capture_pin1, capture_pin0};
    st_d.tb_prev = timebase_64hz;
    // Counting and run phase
    for (int i = 0; i < 4; i++)
    begin
      if (tfall[i] & ~(i[0] & pair[i>>1]))
      begin
        case (st_q.ph[i])
          quad_timer_pkg::PH_IDLE:
            if (run_req[i])
              st_d.ph[i] = quad_timer_pkg::PH_ARMED;
          quad_timer_pkg::PH_ARMED:
            st_d.ph[i] = run_req[i] ? quad_timer_pkg::PH_COUNT
                                    : quad_timer_pkg::PH_IDLE;
          quad_timer_pkg::PH_COUNT:
            if (!run_req[i])
              st_d.ph[i] = quad_timer_pkg::PH_IDLE;
          default: st_d.ph[i] = quad_timer_pkg::PH_IDLE;
        endcase
      end
      if (inc[i])
      begin
        if (ovf_ev[i])
          st_d.cnt[i] = wrap_zero[i] ? `QT_CNT_ZERO : st_q.dat[i];
        else
          st_d.cnt[i] = 8'(st_q.cnt[i] + 8'h01);
      end
      if (irq_ev[i])
      begin
        st_d.ovf[i] = ~st_q.ovf[i];
        st_d.irq[i] = 1'b1;
      end
    end
    // Status read clears the flag; a capture in the same cycle wins
    if (rd_go && rkind == `QT_K_STAT && rt < 2'h2)
      st_d.capf[rt[0]] = 1'b0;
    for (int j = 0; j < 2; j++)
    begin
      if (cap_ev[j])
      begin
        st_d.dat[j] = st_q.cnt[j];
        st_d.capf[j] = 1'b1;
      end
    end
    // Frequency measurement on timers 0 and 2
    for (int j = 0; j < 2; j++)
    begin
      if (st_q.fmeas[j] && !st_q.fm_go[j] && tb_fall)
      begin
        st_d.fm_go[j] = 1'b1;
        st_d.ph[2*j] = quad_timer_pkg::PH_COUNT;
      end
      if (st_q.fm_go[j] && measure_gate_pulse)
        st_d.fmeas[j] = 1'b0;
      if (!st_q.fmeas[j])
        st_d.fm_go[j] = 1'b0;
    end
    // Write channel; a register write overrides counting
    if (awvalid && !st_q.aw_have)
    begin
      st_d.aw_have = 1'b1;
      st_d.aw_addr = awaddr;
    end
    if (wvalid && !st_q.w_have)
    begin
      st_d.w_have = 1'b1;
      st_d.w_data = wdata;
      st_d.w_strb = wstrb;
    end
    if (st_q.bvalid && bready)
      st_d.bvalid = 1'b0;
    if (wr_go)
    begin
      st_d.aw_have = 1'b0;
      st_d.w_have = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = (wkind == `QT_K_NONE) ? `QT_RESP_ERR : `QT_RESP_OK;
      if (st_q.w_strb[0])
      begin
        case (wkind)
          `QT_K_CTRL:
          begin
            st_d.run[wt] = wd[`QT_B_RUN];
            st_d.csel[wt] = wd[`QT_B_CSEL+1:`QT_B_CSEL];
            if (wt == 2'h0)
              st_d.fmeas[0] = wd[`QT_B_FMEAS];
            if (wt == 2'h2)
              st_d.fmeas[1] = wd[`QT_B_FMEAS];
            if (wt < 2'h2)
              st_d.ecap[wt[0]] = wd[`QT_B_ECAP];
          end
          `QT_K_COUNT:
          begin
            st_d.cnt[wt] = wd;
            st_d.dat[wt] = wd;
          end
          `QT_K_DATA: st_d.dat[wt] = wd;
          `QT_K_IRQ:
          begin
            st_d.ien = wd[3:0];
            st_d.master_irq_enable = wd[`QT_B_MIE];
          end
          default: st_d.master_irq_enable = st_q.master_irq_enable;
        endcase
      end
    end
    // Read channel
    if (st_q.rvalid && rready)
      st_d.rvalid = 1'b0;
    if (rd_go)
    begin
      st_d.rvalid = 1'b1;
      st_d.rdata = rword;
      st_d.rresp = (rkind == `QT_K_NONE) ? `QT_RESP_ERR : `QT_RESP_OK;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= '0;
      st_q.ph <= '{default: quad_timer_pkg::PH_IDLE};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // Outputs
  assign awready = ~st_q.aw_have;
  assign wready = ~st_q.w_have;
  assign bvalid = st_q.bvalid;
  assign bresp = st_q.bresp;
  assign arready = ~st_q.rvalid;
  assign rvalid = st_q.rvalid;
  assign rdata = st_q.rdata;
  assign rresp = st_q.rresp;
  assign t0_overflow_toggle = st_q.ovf[0];
  assign t1_overflow_toggle = st_q.ovf[1];
  assign t0_irq = st_q.irq[0];
  assign t1_irq = st_q.irq[1];
  assign t2_irq = st_q.irq[2];
  assign t3_irq = st_q.irq[3];
  assign cpu_irq_req = st_q.master_irq_enable & |(st_q.irq & st_q.ien);

  // Lowest timer wins when several fire together
  always_comb
  begin
    cpu_irq_vector = `QT_VEC_BASE;
    for (int k = 3; k >= 0; k--)
    begin
      if (st_q.irq[k] & st_q.ien[k])
        cpu_irq_vector = 16'(`QT_VEC_BASE + `QT_VEC_STEP * 16'(k));
    end
  end

  // Checks
  logic wr_t0_cnt;
  logic wr_t0_dat;
  assign wr_t0_cnt = wr_go & (wkind == `QT_K_COUNT) & (wt == 2'h0) & st_q.w_strb[0];
  assign wr_t0_dat = wr_go & (wkind == `QT_K_DATA) & (wt == 2'h0) & st_q.w_strb[0];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_IRQ_TOGGLE: assert property (
    st_q.irq[0] |-> st_q.ovf[0] != $past(st_q.ovf[0]))
    else $error("overflow flag did not toggle with interrupt");
  AST_MIE_GATE: assert property (
    cpu_irq_req |-> st_q.master_irq_enable && (st_q.irq & st_q.ien) != 4'h0)
    else $error("interrupt request without enables");
  AST_CNT_WRITE: assert property (
    wr_t0_cnt |=> st_q.cnt[0] == $past(wd) && st_q.dat[0] == $past(wd))
    else $error("counter write did not reach data register");
  AST_DATA_WRITE: assert property (
    wr_t0_dat && !inc[0] |=> $stable(st_q.cnt[0]))
    else $error("data write changed counter");
  AST_CAP_BLOCK: assert property (
    st_q.capf[0] && !wr_t0_cnt && !wr_t0_dat |=> $stable(st_q.dat[0]))
    else $error("capture taken while flag set");
  AST_CAP_WRAP: assert property (
    capmode[0] && ovf_ev[0] && !wr_t0_cnt |=> st_q.cnt[0] == `QT_CNT_ZERO)
    else $error("capture mode did not wrap to zero");
  AST_NO_EARLY: assert property (
    st_q.ph[0] == quad_timer_pkg::PH_IDLE && tfall[0] |=> !inc[0])
    else $error("counted before second clock edge");
  AST_PAIR_RUN: assert property (
    pair[0] && !ovf_ev[0] |-> !inc[1])
    else $error("upper timer counted without lower overflow");
  AST_FM_STOP: assert property (
    st_q.fm_go[0] && measure_gate_pulse && !(wr_go && wkind == `QT_K_CTRL)
    |=> !st_q.fmeas[0] ##1 !st_q.fm_go[0])
    else $error("gate pulse did not end measurement");
  AST_FM_STOP2: assert property (
    st_q.fm_go[1] && measure_gate_pulse && !(wr_go && wkind == `QT_K_CTRL)
    |=> !st_q.fmeas[1] ##1 !st_q.fm_go[1])
    else $error("gate pulse did not end second measurement");

endmodule : quad_timer
`default_nettype wire

// ---- verif/test_quad_timer.sv ----
// Self-checking bench for the quad timer
`timescale 1ns/100ps
`default_nettype none
`include "quad_timer_consts.svh"

module test_quad_timer;
  logic        aclk;
  logic        aresetn;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        ext_even;
  logic        tb64;
  logic        gate;
  logic        cap0;
  logic        ovf0;
  logic        t0p;
  logic        ovf1;
  logic        t1p;
  logic        t2p;
  logic        t3p;
  logic        cpu_irq;
  logic [15:0] cpu_vec;
  logic [15:0] last_vec;
  int          num_errors;
  int          checks;
  int          cpu_cnt;
  int          t0_cnt;
  int          t1_cnt;
  int          t23_cnt;

  quad_timer i_dut (
    .aclk,
    .aresetn,
    .awaddr,
    .awvalid,
    .awready,
    .wdata,
    .wstrb,
    .wvalid,
    .wready,
    .bresp,
    .bvalid,
    .bready,
    .araddr,
    .arvalid,
    .arready,
    .rdata,
    .rresp,
    .rvalid,
    .rready,
    .slow_timebase_clock (1'b0),
    .fast_osc_clock      (1'b0),
    .ext_clk_even_timers (ext_even),
    .ext_clk_odd_timers  (1'b0),
    .timebase_64hz       (tb64),
    .measure_gate_pulse  (gate),
    .capture_pin0        (cap0),
    .capture_pin1        (1'b0),
    .t0_overflow_toggle  (ovf0),
    .t1_overflow_toggle  (ovf1),
    .t0_irq              (t0p),
    .t1_irq              (t1p),
    .t2_irq              (t2p),
    .t3_irq              (t3p),
    .cpu_irq_req         (cpu_irq),
    .cpu_irq_vector      (cpu_vec)
  );

  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // Pulses counted mid-cycle, away from the register updates
  always @(negedge aclk)
  begin
    if (aresetn === 1'b1 && cpu_irq === 1'b1)
    begin
      cpu_cnt++;
      last_vec = cpu_vec;
    end
    if (aresetn === 1'b1 && t0p === 1'b1)
      t0_cnt++;
    if (aresetn === 1'b1 && t1p === 1'b1)
      t1_cnt++;
    if (aresetn === 1'b1 && (t2p === 1'b1 || t3p === 1'b1))
      t23_cnt++;
  end

  task automatic end_of_test();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic stall();
    num_errors++;
    $display("Error handshake expected answer seen none");
    end_of_test();
  endtask : stall

  // Handshakes sampled at the falling edge, acted on after the rising one
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int         n;
    logic       ta;
    logic       tw;
    logic       tb;
    logic [1:0] rs;
    n = 0;
    tb = 1'b0;
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= {24'h00_0000, d};
    wstrb   <= 4'hF;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (!tb && n < 64)
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    if (!tb) stall();
    chk("bresp", rs, er);
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    int          n;
    logic        ta;
    logic        tb;
    logic [31:0] dv;
    logic [1:0]  rs;
    n = 0;
    tb = 1'b0;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    while (!tb && n < 64)
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      tb = rvalid;
      dv = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    if (!tb) stall();
    chk("rresp", rs, er);
    chk("rdata", dv, {24'h00_0000, ed});
    @(posedge aclk);
  endtask : rd

  // Each level held three cycles, above the one-cycle minimum
  task automatic tick(input int k);
    repeat (k)
    begin
      ext_even <= 1'b1;
      repeat (3) @(posedge aclk);
      ext_even <= 1'b0;
      repeat (3) @(posedge aclk);
    end
  endtask : tick

  initial
  begin
    aresetn = 1'b0;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    ext_even = 1'b0;
    tb64 = 1'b1;
    gate = 1'b0;
    cap0 = 1'b0;
    num_errors = 0;
    checks = 0;
    cpu_cnt = 0;
    t0_cnt = 0;
    t1_cnt = 0;
    t23_cnt = 0;
    last_vec = 16'h0000;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(8'h00, 8'h00, `QT_RESP_OK);
    rd(8'h0C, 8'h00, `QT_RESP_OK);
    rd(8'h44, 8'h00, `QT_RESP_ERR);
    wr(8'h44, 8'h5A, `QT_RESP_ERR);
    wr(8'h04, 8'hFE, `QT_RESP_OK);
    rd(8'h08, 8'hFE, `QT_RESP_OK);
    wr(8'h08, 8'hF0, `QT_RESP_OK);
    rd(8'h04, 8'hFE, `QT_RESP_OK);
    wr(8'h40, 8'h11, `QT_RESP_OK);
    // Auto-reload on the external clock
    wr(8'h00, 8'h21, `QT_RESP_OK);
    tick(1);
    rd(8'h04, 8'hFE, `QT_RESP_OK);
    tick(1);
    rd(8'h04, 8'hFF, `QT_RESP_OK);
    tick(1);
    rd(8'h04, 8'hF0, `QT_RESP_OK);
    chk("ovf_pin", ovf0, 1'b1);
    chk("t0_pulses", t0_cnt, 1);
    chk("cpu_irqs", cpu_cnt, 1);
    chk("vector", last_vec, `QT_VEC_BASE);
    rd(8'h0C, 8'h01, `QT_RESP_OK);
    wr(8'h00, 8'h20, `QT_RESP_OK);
    tick(2);
    rd(8'h04, 8'hF0, `QT_RESP_OK);
    // Own enable off: overflow must not reach the processor
    wr(8'h40, 8'h10, `QT_RESP_OK);
    wr(8'h04, 8'hFF, `QT_RESP_OK);
    wr(8'h00, 8'h21, `QT_RESP_OK);
    tick(2);
    chk("t0_pulses", t0_cnt, 2);
    chk("cpu_irqs", cpu_cnt, 1);
    chk("ovf_pin", ovf0, 1'b0);
    rd(8'h04, 8'hFF, `QT_RESP_OK);
    wr(8'h00, 8'h20, `QT_RESP_OK);
    tick(1);
    // Capture, blocking by the flag, clear on status read
    wr(8'h04, 8'h40, `QT_RESP_OK);
    wr(8'h00, 8'h23, `QT_RESP_OK);
    tick(2);
    cap0 <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(8'h08, 8'h41, `QT_RESP_OK);
    tick(1);
    cap0 <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(8'h08, 8'h41, `QT_RESP_OK);
    rd(8'h0C, 8'h02, `QT_RESP_OK);
    rd(8'h0C, 8'h00, `QT_RESP_OK);
    wr(8'h04, 8'hFE, `QT_RESP_OK);
    tick(2);
    rd(8'h04, 8'h00, `QT_RESP_OK);
    wr(8'h00, 8'h20, `QT_RESP_OK);
    tick(1);
    // Cascade: upper run bit left clear on purpose
    wr(8'h14, 8'h00, `QT_RESP_OK);
    wr(8'h04, 8'hFE, `QT_RESP_OK);
    wr(8'h10, 8'h30, `QT_RESP_OK);
    wr(8'h00, 8'h21, `QT_RESP_OK);
    tick(3);
    rd(8'h14, 8'h01, `QT_RESP_OK);
    rd(8'h04, 8'h00, `QT_RESP_OK);
    wr(8'h00, 8'h20, `QT_RESP_OK);
    tick(1);
    // Whole 16-bit overflow reports on the upper timer only
    wr(8'h14, 8'hFF, `QT_RESP_OK);
    wr(8'h04, 8'hFF, `QT_RESP_OK);
    wr(8'h40, 8'h12, `QT_RESP_OK);
    wr(8'h00, 8'h21, `QT_RESP_OK);
    tick(2);
    chk("t1_pulses", t1_cnt, 1);
    chk("t0_pulses", t0_cnt, 3);
    chk("ovf1_pin", ovf1, 1'b1);
    chk("cpu_irqs", cpu_cnt, 2);
    chk("vector", last_vec, 16'h0022);
    rd(8'h04, 8'hFF, `QT_RESP_OK);
    rd(8'h1C, 8'h01, `QT_RESP_OK);
    wr(8'h00, 8'h20, `QT_RESP_OK);
    tick(1);
    // Frequency measurement on timer 2; external clock needs no settling wait
    wr(8'h24, 8'h00, `QT_RESP_OK);
    wr(8'h20, 8'h24, `QT_RESP_OK);
    tick(2);
    rd(8'h24, 8'h00, `QT_RESP_OK);
    tb64 <= 1'b0;
    repeat (3) @(posedge aclk);
    tick(3);
    rd(8'h24, 8'h03, `QT_RESP_OK);
    gate <= 1'b1;
    repeat (4) @(posedge aclk);
    gate <= 1'b0;
    repeat (2) @(posedge aclk);
    rd(8'h20, 8'h20, `QT_RESP_OK);
    chk("t23_pulses", t23_cnt, 0);
    end_of_test();
  end
endmodule : test_quad_timer

`default_nettype wire
